// *** design/cpc_clock_prescale_control.sv ***
// Clock-side control: sleep states, RC trim, special function bits and
// the timer 0/1 and timer 2 prescalers, with APB register access.
// Assumes the timer oscillator pin and external timer 0 input are async
// to pclk and are slower than pclk; the crystal mode is modelled as
// pin samples, so async prescaling still runs on pclk enables.
//
// Functional notes
// - Sleep mode 110 with crystal option enters standby, oscillator kept running
// - Wake from standby takes six clock cycles
// - Mode 111 with crystal enters extended standby; oscillator kept; six cycles
// - Trim value zero lowest frequency, 0xff highest, increasing in between
// - Watchdog and reset time-out stay on watchdog oscillator with RC clock
// - Special function bits 7..4 always read zero
// - Comparator negative input: converter mux when enabled and converter off
// - Pull-up disable forces all pull-ups off
// - Writing one resets timer 2 prescaler; hardware clears; zero ignored
// - Async reset bit reads zero in sync mode, one until reset done
// - Shared prescaler reset hits timers 0 and 1, reads zero always
// - Shared 10-bit prescaler gives ck, /8, /64, /256, /1024, ext, stop
// - Timer 2 source is main clock, or oscillator pin when async selected
// - Async select detaches both oscillator pins from port function
// - Timer 2 selects main, prescaled main, pin clock, or prescaled pin
// - External timer 0 input is sampled on rising cpu clock edges
// - Timer flags live in a flag register, enables in a mask register
// - Sleep only when enable bit set and sleep instruction executes
// - Power-down stops external oscillator; watchdog keeps running
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module cpc_clock_prescale_control
	import cpc_pkg::*;
#(
	parameter int SHARED_BITS = CPC_SHARED_BITS,
	parameter int ASYNC_BITS = CPC_ASYNC_BITS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Straps and pins
	input wire logic crystal_option,
	input wire logic timer_osc_in_pin,
	input wire logic t0_ext_pin,
	input wire logic [7:0] timer_event,
	// Outputs to the rest of the chip
	output logic [7:0] rc_trim_value,
	output logic comparator_use_mux,
	output logic pullup_disable,
	output logic shared_tick_t0,
	output logic shared_tick_t1,
	output logic timer2_tick,
	output logic timer_osc_port_detach,
	output logic watchdog_on_wdt_osc,
	output logic main_osc_run,
	output logic timer2_run,
	output logic cpu_halt
);
	localparam logic [2:0] SEL_STOP = 3'h0;
	localparam logic [2:0] SEL_CK = 3'h1;
	localparam logic [2:0] SEL_8 = 3'h2;
	localparam logic [2:0] SEL_64 = 3'h3;
	localparam logic [2:0] SEL_256 = 3'h4;
	localparam logic [2:0] SEL_1024 = 3'h5;
	localparam logic [2:0] SEL_EXTF = 3'h6;

	typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} cpc_pwr_state_t;

	logic [7:0] trim_reg;
	logic cmux_reg, pud_reg, psr_async_reg;
	logic [7:0] cpu_reg;
	logic async_sel_reg;
	logic [2:0] t0_sel_reg, t1_sel_reg, t2_sel_reg;
	logic [7:0] flag_reg, mask_reg;
	logic [SHARED_BITS-1:0] shared_cnt_reg;
	logic [ASYNC_BITS-1:0] async_cnt_reg;
	logic [2:0] osc_sync_reg, t0_sync_reg;
	logic osc_prev_reg, t0_prev_reg;
	cpc_pwr_state_t pwr_state_reg;
	cpc_sleep_mode_t sleep_mode_reg;
	logic [2:0] wake_cnt_reg;
	logic wr_en, rd_en;
	logic shared_rst, async_rst;
	logic osc_edge, t0_rise, t0_fall;
	logic [SHARED_BITS:0] shared_inc;
	logic [ASYNC_BITS:0] async_inc;
	logic [7:0] sfr_rd;
	logic [31:0] rd_next;
	cpc_power_t pwr_next;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign shared_rst = wr_en && paddr == CPC_SFR_ADDR &&
		pwdata[CPC_SFR_PSR_SHARED_BIT];

	// Register file; no wait states, pready is registered high only in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_reg <= CPC_TRIM_RST;
			cmux_reg <= 1'b0;
			pud_reg <= 1'b0;
			cpu_reg <= CPC_REG_RST;
			async_sel_reg <= 1'b0;
			t0_sel_reg <= SEL_STOP;
			t1_sel_reg <= SEL_STOP;
			t2_sel_reg <= SEL_STOP;
			mask_reg <= CPC_REG_RST;
		end else if (wr_en) begin
			case (paddr)
				CPC_TRIM_ADDR: trim_reg <= pwdata[7:0];
				CPC_SFR_ADDR: begin
					cmux_reg <= pwdata[CPC_SFR_CMUX_BIT];
					pud_reg <= pwdata[CPC_SFR_PUD_BIT];
				end
				CPC_CPU_ADDR: cpu_reg <= pwdata[7:0];
				CPC_ASYNC_ADDR: async_sel_reg <= pwdata[3];
				CPC_TSEL_ADDR: begin
					t0_sel_reg <= pwdata[2:0];
					t1_sel_reg <= pwdata[6:4];
					t2_sel_reg <= pwdata[10:8];
				end
				CPC_MASK_ADDR: mask_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Timer flags: hardware set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= CPC_REG_RST;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (timer_event[i]) begin
					flag_reg[i] <= 1'b1;
				end else if (wr_en && paddr == CPC_FLAG_ADDR && pwdata[i]) begin
					flag_reg[i] <= 1'b0;
				end
			end
		end
	end

	// Async prescaler reset: held until the next oscillator sample completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psr_async_reg <= 1'b0;
		end else if (!async_sel_reg) begin
			psr_async_reg <= 1'b0;
		end else if (wr_en && paddr == CPC_SFR_ADDR &&
			pwdata[CPC_SFR_PSR_ASYNC_BIT]) begin
			psr_async_reg <= 1'b1;
		end else if (osc_edge) begin
			psr_async_reg <= 1'b0;
		end
	end
	// In sync mode the reset acts at once on the write
	assign async_rst = async_sel_reg ? (psr_async_reg & osc_edge) :
		(wr_en && paddr == CPC_SFR_ADDR && pwdata[CPC_SFR_PSR_ASYNC_BIT]);

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_sync_reg <= 3'h0;
			t0_sync_reg <= 3'h0;
			osc_prev_reg <= 1'b0;
			t0_prev_reg <= 1'b0;
		end else begin
			osc_sync_reg <= {osc_sync_reg[1:0], timer_osc_in_pin};
			t0_sync_reg <= {t0_sync_reg[1:0], t0_ext_pin};
			if (osc_sync_reg[2] == osc_sync_reg[1]) begin
				osc_prev_reg <= osc_sync_reg[2];
			end
			if (t0_sync_reg[2] == t0_sync_reg[1]) begin
				t0_prev_reg <= t0_sync_reg[2];
			end
		end
	end
	assign osc_edge = async_sel_reg && osc_sync_reg[2] == osc_sync_reg[1] &&
		osc_sync_reg[2] && !osc_prev_reg;
	assign t0_rise = t0_sync_reg[2] == t0_sync_reg[1] && t0_sync_reg[2] &&
		!t0_prev_reg;
	assign t0_fall = t0_sync_reg[2] == t0_sync_reg[1] && !t0_sync_reg[2] &&
		t0_prev_reg;

	// Prescaler counters
	assign shared_inc = {1'b0, shared_cnt_reg} + 1'b1;
	assign async_inc = {1'b0, async_cnt_reg} + 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_cnt_reg <= '0;
		end else if (shared_rst) begin
			shared_cnt_reg <= '0;
		end else begin
			shared_cnt_reg <= shared_inc[SHARED_BITS-1:0];
		end
	end
	// Timer 2 prescaler steps on main clock or on the pin clock edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_cnt_reg <= '0;
		end else if (async_rst) begin
			async_cnt_reg <= '0;
		end else if (!async_sel_reg || osc_edge) begin
			async_cnt_reg <= async_inc[ASYNC_BITS-1:0];
		end
	end

	// Tick when the low n bits roll over; those bits are all ones there and wrap on that edge
	function automatic logic shared_tap(input logic [2:0] sel,
		input logic [SHARED_BITS-1:0] cnt, input logic rise,
		input logic fall);
		case (sel)
			SEL_STOP: shared_tap = 1'b0;
			SEL_CK: shared_tap = 1'b1;
			SEL_8: shared_tap = cnt[2:0] == 3'h7;
			SEL_64: shared_tap = cnt[5:0] == 6'h3f;
			SEL_256: shared_tap = cnt[7:0] == 8'hff;
			SEL_1024: shared_tap = cnt[9:0] == 10'h3ff;
			SEL_EXTF: shared_tap = fall;
			default: shared_tap = rise;
		endcase
	endfunction
	function automatic logic async_tap(input logic [2:0] sel,
		input logic [ASYNC_BITS-1:0] cnt, input logic step);
		case (sel)
			3'h0: async_tap = 1'b0;
			3'h1: async_tap = step;
			3'h2: async_tap = step && cnt[2:0] == 3'h7;
			3'h3: async_tap = step && cnt[4:0] == 5'h1f;
			3'h4: async_tap = step && cnt[5:0] == 6'h3f;
			3'h5: async_tap = step && cnt[6:0] == 7'h7f;
			3'h6: async_tap = step && cnt[7:0] == 8'hff;
			default: async_tap = step && cnt[9:0] == 10'h3ff;
		endcase
	endfunction

	// Timer clock enables, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_tick_t0 <= 1'b0;
			shared_tick_t1 <= 1'b0;
			timer2_tick <= 1'b0;
		end else begin
			shared_tick_t0 <= !shared_rst &&
				shared_tap(t0_sel_reg, shared_cnt_reg, t0_rise, t0_fall);
			shared_tick_t1 <= !shared_rst &&
				shared_tap(t1_sel_reg, shared_cnt_reg, t0_rise, t0_fall);
			timer2_tick <= !async_rst && async_tap(t2_sel_reg, async_cnt_reg,
				!async_sel_reg || osc_edge);
		end
	end

	// Sleep controller: a write of the sleep command stands for the
	// instruction, a wake command for a valid wake-up condition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_state_reg <= ST_RUN;
			sleep_mode_reg <= CPC_SM_IDLE;
			wake_cnt_reg <= 3'h0;
		end else begin
			case (pwr_state_reg)
				ST_RUN: begin
					if (wr_en && paddr == CPC_CMD_ADDR &&
						pwdata[CPC_CMD_SLEEP_BIT] && cpu_reg[CPC_CPU_SE_BIT]) begin
						pwr_state_reg <= ST_SLEEP;
						sleep_mode_reg <= cpc_sleep_mode_t'(
							cpu_reg[CPC_CPU_SM_LSB +: 3]);
					end
				end
				ST_SLEEP: begin
					if (wr_en && paddr == CPC_CMD_ADDR &&
						pwdata[CPC_CMD_WAKE_BIT]) begin
						pwr_state_reg <= ST_WAKE;
						wake_cnt_reg <= 3'(CPC_WAKE_FAST_CYC - 1);
					end
				end
				ST_WAKE: begin
					if (wake_cnt_reg == 3'h0) begin
						pwr_state_reg <= ST_RUN;
					end else begin
						wake_cnt_reg <= wake_cnt_reg - 3'h1;
					end
				end
				default: pwr_state_reg <= ST_RUN;
			endcase
		end
	end

	// Power controls from the current sleep state
	always_comb begin
		pwr_next = '{main_osc_run: 1'b1, timer2_run: 1'b1, cpu_halt: 1'b0};
		if (pwr_state_reg != ST_RUN) begin
			pwr_next.cpu_halt = 1'b1;
		end
		if (pwr_state_reg == ST_SLEEP) begin
			case (sleep_mode_reg)
				CPC_SM_PDOWN: begin
					pwr_next.main_osc_run = 1'b0;
					pwr_next.timer2_run = 1'b0;
				end
				CPC_SM_PSAVE: begin
					pwr_next.main_osc_run = 1'b0;
					pwr_next.timer2_run = async_sel_reg;
				end
				CPC_SM_STBY: begin
					pwr_next.main_osc_run = crystal_option;
					pwr_next.timer2_run = 1'b0;
				end
				CPC_SM_XSTBY: begin
					pwr_next.main_osc_run = crystal_option;
					pwr_next.timer2_run = async_sel_reg;
				end
				default: ;
			endcase
		end
	end

	assign sfr_rd = {4'h0, cmux_reg, pud_reg, psr_async_reg, 1'b0};
	always_comb begin
		case (paddr)
			CPC_TRIM_ADDR: rd_next = {24'h0, trim_reg};
			CPC_SFR_ADDR: rd_next = {24'h0, sfr_rd};
			CPC_CPU_ADDR: rd_next = {24'h0, cpu_reg};
			CPC_ASYNC_ADDR: rd_next = {28'h0, async_sel_reg, 3'h0};
			CPC_TSEL_ADDR: rd_next = {21'h0, t2_sel_reg, 1'b0, t1_sel_reg,
				1'b0, t0_sel_reg};
			CPC_STAT_ADDR: rd_next = {28'h0, pwr_state_reg != ST_RUN,
				sleep_mode_reg};
			CPC_FLAG_ADDR: rd_next = {24'h0, flag_reg};
			CPC_MASK_ADDR: rd_next = {24'h0, mask_reg};
			default: rd_next = 32'h0;
		endcase
	end

	// Bus answers and chip outputs, all from flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (rd_en) begin
				prdata <= rd_next;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_trim_value <= CPC_TRIM_RST;
			comparator_use_mux <= 1'b0;
			pullup_disable <= 1'b0;
			timer_osc_port_detach <= 1'b0;
			watchdog_on_wdt_osc <= 1'b1;
			main_osc_run <= 1'b1;
			timer2_run <= 1'b1;
			cpu_halt <= 1'b0;
		end else begin
			rc_trim_value <= trim_reg;
			comparator_use_mux <= cmux_reg & ~cpu_reg[CPC_CPU_CONV_BIT];
			pullup_disable <= pud_reg;
			timer_osc_port_detach <= async_sel_reg;
			watchdog_on_wdt_osc <= 1'b1;
			main_osc_run <= pwr_next.main_osc_run;
			timer2_run <= pwr_next.timer2_run;
			cpu_halt <= pwr_next.cpu_halt;
		end
	end
endmodule

// *** design/cpc_pkg.sv ***
// Package for the clock and prescaler control block.
// Assumes an APB slave with 32-bit data; every register takes one word.
package cpc_pkg;
	// Byte offsets (printed offset 0x31 is not a multiple of four: index*4)
	localparam logic [7:0] CPC_TRIM_IDX = 8'h31;
	localparam logic [11:0] CPC_TRIM_ADDR = {2'b00, CPC_TRIM_IDX, 2'b00};
	localparam logic [11:0] CPC_SFR_ADDR = 12'h000;
	localparam logic [11:0] CPC_CPU_ADDR = 12'h004;
	localparam logic [11:0] CPC_ASYNC_ADDR = 12'h008;
	localparam logic [11:0] CPC_TSEL_ADDR = 12'h00c;
	localparam logic [11:0] CPC_CMD_ADDR = 12'h010;
	localparam logic [11:0] CPC_STAT_ADDR = 12'h014;
	localparam logic [11:0] CPC_FLAG_ADDR = 12'h018;
	localparam logic [11:0] CPC_MASK_ADDR = 12'h01c;
	// Special function register fields
	localparam int CPC_SFR_CMUX_BIT = 3;
	localparam int CPC_SFR_PUD_BIT = 2;
	localparam int CPC_SFR_PSR_ASYNC_BIT = 1;
	localparam int CPC_SFR_PSR_SHARED_BIT = 0;
	// CPU control fields
	localparam int CPC_CPU_SE_BIT = 7;
	localparam int CPC_CPU_SM_LSB = 4;
	localparam int CPC_CPU_CONV_BIT = 0;
	// Command register fields
	localparam int CPC_CMD_SLEEP_BIT = 0;
	localparam int CPC_CMD_WAKE_BIT = 1;
	// Reset values
	localparam logic [7:0] CPC_TRIM_RST = 8'h00;
	localparam logic [7:0] CPC_REG_RST = 8'h00;
	// Timing
	localparam int CPC_WAKE_FAST_CYC = 6;
	localparam int CPC_SHARED_BITS = 10;
	localparam int CPC_ASYNC_BITS = 10;
	typedef enum logic [2:0] {
		CPC_SM_IDLE, CPC_SM_NOISE, CPC_SM_PDOWN, CPC_SM_PSAVE,
		CPC_SM_RSV4, CPC_SM_RSV5, CPC_SM_STBY, CPC_SM_XSTBY
	} cpc_sleep_mode_t;
	typedef struct packed {
		logic main_osc_run;
		logic timer2_run;
		logic cpu_halt;
	} cpc_power_t;
endpackage

// *** bench/cpc_ext_clk_model.sv ***
// Model of the external timer clocks: watch crystal or timer 0 source.
// Assumes pclk as time base; the pin rests low while not running.
`timescale 1ns/1ps
module cpc_ext_clk_model (
	// Time base and control
	input wire logic pclk,
	input wire logic run,
	input wire logic [7:0] half,
	// Pin
	output logic pin
);
	logic [7:0] cnt;
	// Edges never closer than one pclk period, so each one is sampled
	always @(posedge pclk) begin
		if (!run) begin
			cnt <= 8'h00;
			pin <= 1'b0;
		end else if (cnt >= half - 8'h01) begin
			cnt <= 8'h00;
			pin <= ~pin;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// *** bench/cpc_props.sv ***
// Assertion checker for the clock and prescaler control block.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/1ps
module cpc_props
	import cpc_pkg::*;
(
	// Clock, reset and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Chip side
	input wire logic crystal_option,
	input wire logic [7:0] rc_trim_value,
	input wire logic pullup_disable,
	input wire logic timer_osc_port_detach,
	input wire logic watchdog_on_wdt_osc,
	input wire logic main_osc_run,
	input wire logic cpu_halt
);
	logic wr;
	logic rd;
	logic se_reg;
	logic [2:0] mode_reg;
	logic [31:0] wd_reg;
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Shadows of written data: sleep enable and sleep mode are judged only from them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			se_reg <= 1'b0;
			mode_reg <= 3'h0;
			wd_reg <= 32'h0000_0000;
		end else if (wr) begin
			wd_reg <= pwdata;
			if (paddr == CPC_CPU_ADDR) begin
				se_reg <= pwdata[CPC_CPU_SE_BIT];
				mode_reg <= pwdata[6:4];
			end
		end
	end
	a_rsv_zero: assert property (
		rd && paddr == CPC_SFR_ADDR |-> prdata[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	a_shared_rd_zero: assert property (
		rd && paddr == CPC_SFR_ADDR |-> !prdata[0])
		else $error("shared reset bit read one");
	a_async_rd_zero: assert property (
		rd && paddr == CPC_SFR_ADDR && !timer_osc_port_detach |-> !prdata[1])
		else $error("async reset bit read one in sync mode");
	a_trim_copy: assert property (
		wr && paddr == CPC_TRIM_ADDR |=> ##[0:1] rc_trim_value == wd_reg[7:0])
		else $error("trim output does not follow write");
	a_pud_follow: assert property (
		wr && paddr == CPC_SFR_ADDR |=> ##[0:1]
		pullup_disable == wd_reg[CPC_SFR_PUD_BIT])
		else $error("pull-up disable does not follow write");
	a_pin_detach: assert property (
		wr && paddr == CPC_ASYNC_ADDR |=> ##[0:1]
		timer_osc_port_detach == wd_reg[3])
		else $error("pin detach does not follow async select");
	a_wdt_osc: assert property (watchdog_on_wdt_osc)
		else $error("watchdog left its own oscillator");
	a_sleep_gate: assert property (
		wr && paddr == CPC_CMD_ADDR && pwdata[0] && !se_reg && !cpu_halt
		|=> !cpu_halt [*4])
		else $error("sleep entered without enable");
	a_sleep_enter: assert property (
		wr && paddr == CPC_CMD_ADDR && pwdata[0] && se_reg |-> ##[1:4] cpu_halt)
		else $error("sleep not entered");
	a_osc_kept: assert property (
		cpu_halt && crystal_option && mode_reg[2:1] == 2'b11 |-> main_osc_run)
		else $error("oscillator stopped in standby");
	a_osc_stop: assert property (
		$rose(cpu_halt) && mode_reg == CPC_SM_PDOWN |-> ##[0:2] !main_osc_run)
		else $error("oscillator kept in power-down");
	a_fast_wake: assert property (
		wr && paddr == CPC_CMD_ADDR && pwdata[1] && cpu_halt
		|=> cpu_halt [*5] ##[1:4] !cpu_halt)
		else $error("wake not six cycles");
	cover property ($rose(cpu_halt) && main_osc_run);
	cover property ($fell(cpu_halt));
	cover property (rd && paddr == CPC_SFR_ADDR && prdata[1]);
endmodule

// *** bench/cpc_clock_prescale_control_tb_top.sv ***
// Testbench for the clock and prescaler control block.
// Drives APB itself; two pin models supply the external clocks.
`timescale 1ns/1ps
module cpc_clock_prescale_control_tb_top
	import cpc_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, crystal_option;
	logic osc_run, t0_run, timer_osc_in_pin, t0_ext_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] timer_event, rc_trim_value;
	logic pready, pslverr, comparator_use_mux, pullup_disable;
	logic shared_tick_t0, shared_tick_t1, timer2_tick, timer_osc_port_detach;
	logic watchdog_on_wdt_osc, main_osc_run, timer2_run, cpu_halt;
	logic [2:0] tk;
	int errors = 0;
	int cmp_count = 0;
	int sp[5] = '{1, 8, 64, 256, 1024};
	int t2p[7] = '{1, 8, 32, 64, 128, 256, 1024};
	logic [2:0] md[4] = '{3'h6, 3'h7, 3'h2, 3'h6};
	assign tk = {timer2_tick, shared_tick_t1, shared_tick_t0};
	always #2.5 pclk = ~pclk;
	cpc_clock_prescale_control i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_option(crystal_option), .timer_osc_in_pin(timer_osc_in_pin),
		.t0_ext_pin(t0_ext_pin), .timer_event(timer_event),
		.rc_trim_value(rc_trim_value), .comparator_use_mux(comparator_use_mux),
		.pullup_disable(pullup_disable), .shared_tick_t0(shared_tick_t0),
		.shared_tick_t1(shared_tick_t1), .timer2_tick(timer2_tick),
		.timer_osc_port_detach(timer_osc_port_detach),
		.watchdog_on_wdt_osc(watchdog_on_wdt_osc),
		.main_osc_run(main_osc_run), .timer2_run(timer2_run),
		.cpu_halt(cpu_halt));
	cpc_ext_clk_model i_osc (.pclk(pclk), .run(osc_run), .half(8'h0a),
		.pin(timer_osc_in_pin));
	cpc_ext_clk_model i_t0 (.pclk(pclk), .run(t0_run), .half(8'h04),
		.pin(t0_ext_pin));
	task automatic close_out;
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic hang;
		errors++;
		close_out();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	// Request held until pready is sampled high; no latency assumed
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) hang();
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic tick_wait(input int s, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (tk[s] !== 1'b1 && n < 3000);
		if (n >= 3000) hang();
	endtask
	// First ticks after a select change may be partial, so skip two
	task automatic gap(input int s, input int e, input string nm);
		int n;
		tick_wait(s, n);
		tick_wait(s, n);
		tick_wait(s, n);
		chk(nm, e, n);
	endtask
	initial begin
		int n;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		crystal_option = 1'b1;
		osc_run = 1'b0;
		t0_run = 1'b0;
		timer_event = 8'h00;
		idle(4);
		presetn <= 1'b1;
		chk("wdt osc", 1, watchdog_on_wdt_osc);
		rd(CPC_TRIM_ADDR, CPC_TRIM_RST, "trim rst");
		rd(CPC_SFR_ADDR, CPC_REG_RST, "sfr rst");
		wr(CPC_TRIM_ADDR, 32'hff);
		rd(CPC_TRIM_ADDR, 32'hff, "trim");
		chk("trim out", 8'hff, rc_trim_value);
		wr(12'h100, 32'hff);
		rd(12'h100, 32'h0, "unmapped");
		chk("slverr", 0, pslverr);
		wr(CPC_SFR_ADDR, 32'hff);
		rd(CPC_SFR_ADDR, 32'h0c, "sfr");
		chk("pud", 1, pullup_disable);
		chk("cmux", 1, comparator_use_mux);
		wr(CPC_CPU_ADDR, 32'h1);
		idle(3);
		chk("cmux conv", 0, comparator_use_mux);
		wr(CPC_SFR_ADDR, 32'h0);
		idle(3);
		chk("pud off", 0, pullup_disable);
		for (int i = 1; i < 6; i++) begin
			wr(CPC_TSEL_ADDR, i);
			gap(0, sp[i-1], "t0 div");
		end
		wr(CPC_TSEL_ADDR, 32'h20);
		gap(1, 8, "t1 div");
		wr(CPC_TSEL_ADDR, 32'h3);
		tick_wait(0, n);
		wr(CPC_SFR_ADDR, 32'h1);
		tick_wait(0, n);
		chk("psr shared", 1, n >= 63 && n <= 67);
		for (int i = 1; i < 8; i++) begin
			wr(CPC_TSEL_ADDR, i << 8);
			gap(2, t2p[i-1], "t2 div");
		end
		wr(CPC_ASYNC_ADDR, 32'h8);
		idle(3);
		chk("detach", 1, timer_osc_port_detach);
		osc_run <= 1'b1;
		wr(CPC_TSEL_ADDR, 32'h100);
		gap(2, 20, "t2 pin");
		wr(CPC_TSEL_ADDR, 32'h200);
		gap(2, 160, "t2 pin div");
		osc_run <= 1'b0;
		idle(8);
		wr(CPC_SFR_ADDR, 32'h2);
		rd(CPC_SFR_ADDR, 32'h2, "psr async busy");
		osc_run <= 1'b1;
		idle(40);
		rd(CPC_SFR_ADDR, 32'h0, "psr async done");
		wr(CPC_ASYNC_ADDR, 32'h0);
		idle(3);
		chk("attach", 0, timer_osc_port_detach);
		t0_run <= 1'b1;
		wr(CPC_TSEL_ADDR, 32'h7);
		gap(0, 8, "t0 rise");
		wr(CPC_TSEL_ADDR, 32'h6);
		gap(0, 8, "t0 fall");
		timer_event <= 8'h05;
		@(posedge pclk);
		timer_event <= 8'h00;
		rd(CPC_FLAG_ADDR, 32'h5, "flags");
		wr(CPC_FLAG_ADDR, 32'h1);
		rd(CPC_FLAG_ADDR, 32'h4, "flag clear");
		wr(CPC_MASK_ADDR, 32'ha5);
		rd(CPC_MASK_ADDR, 32'ha5, "mask");
		wr(CPC_CPU_ADDR, 32'h60);
		wr(CPC_CMD_ADDR, 32'h1);
		idle(4);
		chk("no sleep", 0, cpu_halt);
		// Last pass drops the crystal option, so standby stops the oscillator
		for (int i = 0; i < 4; i++) begin
			crystal_option <= (i != 3);
			wr(CPC_CPU_ADDR, {24'h0, 1'b1, md[i], 4'h0});
			wr(CPC_CMD_ADDR, 32'h1);
			idle(4);
			chk("halt", 1, cpu_halt);
			chk("osc", md[i] != 3'h2 && i != 3, main_osc_run);
			chk("t2 run", 0, timer2_run);
			rd(CPC_STAT_ADDR, {28'h0, 1'b1, md[i]}, "stat");
			wr(CPC_CMD_ADDR, 32'h2);
			n = 0;
			while (cpu_halt !== 1'b0 && n < 20) begin
				@(posedge pclk);
				n++;
			end
			chk("wake", 1, n >= 5 && n <= 9);
		end
		close_out();
	end
endmodule
bind cpc_clock_prescale_control cpc_props i_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.crystal_option(crystal_option), .rc_trim_value(rc_trim_value),
	.pullup_disable(pullup_disable),
	.timer_osc_port_detach(timer_osc_port_detach),
	.watchdog_on_wdt_osc(watchdog_on_wdt_osc),
	.main_osc_run(main_osc_run), .cpu_halt(cpu_halt));
